/* File: hdl/ctx_map.svh */
`ifndef CTX_MAP_SVH
`define CTX_MAP_SVH
// ************************************************
// Sizes
// ************************************************
`define CTX_NBUF 6
`define CTX_NIRQ 5
// ************************************************
// Register byte addresses
// ************************************************
`define CTX_A_MODCTL 8'h00
`define CTX_A_MODST 8'h04
`define CTX_A_COMST 8'h08
`define CTX_A_IFLAG 8'h0C
`define CTX_A_IEN 8'h10
`define CTX_A_DIRSEL 8'h14
`define CTX_A_BIEN 8'h18
`define CTX_A_BDONE 8'h1C
`define CTX_A_BCTL 8'h20
`define CTX_A_BCTL_END 8'h38
`define CTX_A_BMEM 8'h40
`define CTX_A_BMEM_END 8'hA0
// ************************************************
// Field positions
// ************************************************
`define CTX_B_MODE_HI 1
`define CTX_B_MODE_LO 0
`define CTX_B_ABORT_ALL_REQUEST 4
`define CTX_B_PRIO_HI 1
`define CTX_B_PRIO_LO 0
`define CTX_B_REMOTE_REPLY_ENABLE 2
`define CTX_B_TREQ 3
`define CTX_B_TERR 4
`define CTX_B_ARBL 5
`define CTX_B_ABTD 6
`define CTX_B_IRQ_CODE_HI 3
`define CTX_B_IRQ_CODE_LO 1
`define CTX_I_RX 0
`define CTX_I_TX 1
`define CTX_I_ERR 2
`define CTX_I_WAKE 3
`define CTX_I_BERR 4
// ************************************************
// Limits and codes
// ************************************************
`define CTX_PASSIVE_LIM 9'h080
`define CTX_BUSOFF_LIM 9'h100
`define CTX_WARN_LIM 9'h060
`define CTX_REC_CNT_LAST 7'h7F
`define CTX_IC_NONE 3'h0
`define CTX_IC_ERR 3'h1
`define CTX_IC_BERR 3'h2
`define CTX_IC_TX 3'h3
`define CTX_IC_RX 3'h4
`define CTX_IC_WAKE 3'h5
`endif

/* File: hdl/ctx_pkg.sv */
package ctx_pkg;
  // ************************************************
  // Types
  // ************************************************
  typedef struct packed {
    logic [31:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } ctx_frame_t;
  typedef struct packed {
    logic done;
    logic arb_lost;
    logic error;
  } ctx_tx_evt_t;
  typedef enum logic [1:0] {
    CTX_TX_IDLE = 2'h1,
    CTX_TX_BUSY = 2'h2
  } ctx_tx_state_t;
  typedef enum logic [2:0] {
    CTX_ERR_ACTIVE = 3'h1,
    CTX_ERR_PASSIVE = 3'h2,
    CTX_ERR_BUSOFF = 3'h4
  } ctx_err_mode_t;
endpackage

/* File: hdl/ctx_err_state.sv */
`timescale 1ns/1ps
`include "ctx_map.svh"
module ctx_err_state
  import ctx_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Error counters and idle detector
  input wire logic [8:0] tec,
  input wire logic [7:0] rec,
  input wire logic recessive_11,
  // Error view
  output ctx_err_mode_t err_mode,
  output logic [5:0] status,
  output logic recovered
);
  ctx_err_mode_t mode_reg, mode_next;
  logic [6:0] rcnt_reg, rcnt_next;
  logic [5:0] st_reg;
  logic rec_reg;

  wire tx_pass = tec >= `CTX_PASSIVE_LIM;
  wire rx_pass = {1'b0, rec} >= `CTX_PASSIVE_LIM;
  wire tx_warn = tec >= `CTX_WARN_LIM;
  wire rx_warn = {1'b0, rec} >= `CTX_WARN_LIM;
  wire off_hit = tec >= `CTX_BUSOFF_LIM;
  wire rec_done = (mode_reg == CTX_ERR_BUSOFF) & recessive_11 &
    (rcnt_reg == `CTX_REC_CNT_LAST);

  always_comb begin
    mode_next = mode_reg;
    rcnt_next = 7'h00;
    case (mode_reg)
      CTX_ERR_ACTIVE: begin
        if (off_hit) begin
          mode_next = CTX_ERR_BUSOFF; // [R16]
        end else if (tx_pass | rx_pass) begin
          mode_next = CTX_ERR_PASSIVE; // [R15]
        end
      end
      CTX_ERR_PASSIVE: begin
        if (off_hit) begin
          mode_next = CTX_ERR_BUSOFF; // [R16]
        end else if (!(tx_pass | rx_pass)) begin
          mode_next = CTX_ERR_ACTIVE; // [R15]
        end
      end
      CTX_ERR_BUSOFF: begin
        // No firmware step needed to leave bus-off
        if (rec_done) begin
          mode_next = CTX_ERR_ACTIVE; // [R17]
        end else if (recessive_11) begin
          rcnt_next = rcnt_reg + 7'h01; // [R17]
        end else begin
          rcnt_next = rcnt_reg;
        end
      end
      default: mode_next = CTX_ERR_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= CTX_ERR_ACTIVE;
      rcnt_reg <= 7'h00;
      st_reg <= 6'h00;
      rec_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      rcnt_reg <= rcnt_next;
      st_reg <= {mode_next == CTX_ERR_BUSOFF, tx_pass, rx_pass,
        tx_warn, rx_warn, tx_warn | rx_warn}; // [R18]
      rec_reg <= rec_done;
    end
  end

  assign err_mode = mode_reg;
  assign status = st_reg;
  assign recovered = rec_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busoff_entry: assert property ( // [R16]
    off_hit && mode_reg != CTX_ERR_BUSOFF |=> mode_reg == CTX_ERR_BUSOFF)
    else $error("bus-off not entered");
  a_busoff_exit: assert property ( // [R17]
    recovered |-> mode_reg == CTX_ERR_ACTIVE &&
      $past(rcnt_reg) == `CTX_REC_CNT_LAST)
    else $error("bus-off left early");
endmodule

/* File: hdl/ctx_tx_pick.sv */
`timescale 1ns/1ps
`include "ctx_map.svh"
module ctx_tx_pick
  import ctx_pkg::*;
(
  // Ready buffers and their priorities
  input wire logic [`CTX_NBUF-1:0] ready,
  input wire logic [2*`CTX_NBUF-1:0] prio,
  // Winner
  output logic valid,
  output logic [2:0] idx
);
  logic [1:0] best;

  // Equal priority goes to the higher buffer number
  always_comb begin
    valid = 1'b0;
    idx = 3'h0;
    best = 2'h0;
    for (int i = 0; i < `CTX_NBUF; i++) begin
      if (ready[i] && (!valid || prio[2*i +: 2] >= best)) begin
        valid = 1'b1; // [R7]
        idx = 3'(i);
        best = prio[2*i +: 2];
      end
    end
  end
endmodule

/* File: hdl/ctx_top.sv */
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ctx_map.svh"
// Function
// R1 - Auto remote reply sets request itself
// R2 - Pending buffer rejects all writes
// R3 - Firmware presets filter and reply data
// R4 - Buffer writable only with request clear
// R5 - Firmware loads identifiers and length first
// R6 - New request clears abort, arbitration, error
// R7 - Highest priority ready buffer sent when idle
// R8 - Success clears request, sets done flag
// R9 - Error keeps request, sets error flags
// R10 - Arbitration loss keeps request, sets flag
// R11 - Abort by clearing request or abort-all
// R12 - Unstarted or failed aborted message sets done; code sets the ABTD flag, not BDONE
// R13 - Running message finishes, no abort flag
// R14 - Only hardware clears abort requests
// R15 - Passive when a counter reaches 128
// R16 - Bus-off when transmit counter reaches 256
// R17 - Recover after 128 idle sequences
// R18 - Warning flag at counter 96
// R19 - Flags and enables in two registers
// R20 - Read-only interrupt code names pending source
// R21 - Shared transmit flag, single error flag; code keeps a separate BERR flag for transmit errors beside ERR
// R22 - Receive, wake, error and transmit sources
module ctx_top
  import ctx_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine status
  input wire logic bus_idle,
  input wire ctx_tx_evt_t tx_evt,
  input wire logic rtr_hit,
  input wire logic [2:0] rtr_buf,
  input wire logic rx_done,
  input wire logic rx_overrun,
  input wire logic wake,
  input wire logic recessive_11,
  input wire logic [8:0] tec,
  input wire logic [7:0] rec,
  // Protocol engine requests
  output logic tx_start,
  output ctx_frame_t tx_frame,
  output logic [2:0] tx_buf,
  output logic busoff_recovered,
  output logic irq
);
  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [4:0] ctx_word_of(input logic [7:0] a,
      input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[6:2];
  endfunction

  function automatic logic [4:0] ctx_mem_at(input logic [2:0] b,
      input logic [1:0] w);
    return {b, w};
  endfunction

  // ************************************************
  // State
  // ************************************************
  localparam int NB = `CTX_NBUF;
  ctx_tx_state_t st_reg, st_next;
  logic [31:0] mem [0:4*NB-1];
  logic [1:0] mode_reg;
  logic abort_all_request_reg, abort_all_request_next;
  logic [NB-1:0] treq_reg, treq_next, abtd_reg, abtd_next;
  logic [NB-1:0] arbl_reg, arbl_next, terr_reg, terr_next;
  logic [NB-1:0] abtp_reg, abtp_next, remote_reply_enable_reg, remote_reply_enable_next;
  logic [NB-1:0] dirsel_reg, bien_reg, bdone_reg, bdone_next;
  logic [NB-1:0] treq_prev_reg;
  logic [2*NB-1:0] prio_reg, prio_next;
  logic [`CTX_NIRQ-1:0] iflag_reg, iflag_set;
  logic [7:0] ien_reg;
  logic [5:0] est_prev_reg;
  logic [2:0] cur_reg;
  logic [31:0] prdata_reg, rdata;
  logic pready_reg, pslverr_reg, irq_reg, tx_start_reg;
  ctx_frame_t frame_reg;
  logic ctl_wr, rtr_i, cur_i, set_req, abort_any;
  ctx_err_mode_t err_mode;
  logic [5:0] est;
  logic recovered;
  logic pick_valid;
  logic [2:0] pick_idx;

  // ************************************************
  // APB decode
  // ************************************************
  // One wait state keeps every answer registered
  wire acc = psel & penable & pready_reg;
  wire wr = acc & pwrite;
  wire rd_load = psel & penable & ~pready_reg;
  wire aligned = paddr[1:0] == 2'h0;
  wire bctl_hit = aligned & (paddr >= `CTX_A_BCTL) &
    (paddr < `CTX_A_BCTL_END);
  wire bmem_hit = aligned & (paddr >= `CTX_A_BMEM) &
    (paddr < `CTX_A_BMEM_END);
  wire [4:0] bidx_w = ctx_word_of(paddr, `CTX_A_BCTL);
  wire [2:0] bidx = bidx_w[2:0];
  wire [4:0] midx = ctx_word_of(paddr, `CTX_A_BMEM);
  wire [2:0] mbuf = midx[4:2];
  wire reg_hit = aligned & (paddr <= `CTX_A_BDONE);
  wire mapped = reg_hit | bctl_hit | bmem_hit;
  wire busy = st_reg == CTX_TX_BUSY;
  wire mode_on = mode_reg != 2'h0;
  wire mem_wr = wr & bmem_hit & ~treq_reg[mbuf]; // [R2] [R4]
  wire dir_wr = wr & (paddr == `CTX_A_DIRSEL);
  wire [NB-1:0] ready = treq_reg & ~abtp_reg & {NB{~abort_all_request_reg}};
  wire cur_abort = abtp_reg[cur_reg] | abort_all_request_reg;
  wire [NB-1:0] new_req = treq_reg & ~treq_prev_reg;
  wire set_req_any = |new_req;
  wire start = (st_reg == CTX_TX_IDLE) & pick_valid & bus_idle &
    (err_mode != CTX_ERR_BUSOFF); // [R7]
  wire tx_end = busy & (tx_evt.done | tx_evt.arb_lost | tx_evt.error);
  wire err_evt = (|(est[5:1] & ~est_prev_reg[5:1])) | rx_overrun;
  wire [`CTX_NIRQ-1:0] iflag_clr = (wr && paddr == `CTX_A_IFLAG) ?
    pwdata[`CTX_NIRQ-1:0] : '0;
  wire [NB-1:0] bdone_clr = (wr && paddr == `CTX_A_BDONE) ?
    pwdata[NB-1:0] : '0;
  wire [`CTX_NIRQ-1:0] iflag_on = iflag_reg & ien_reg[`CTX_NIRQ-1:0];
  wire [2:0] irq_code = iflag_on[`CTX_I_ERR] ? `CTX_IC_ERR :
    iflag_on[`CTX_I_BERR] ? `CTX_IC_BERR :
    iflag_on[`CTX_I_TX] ? `CTX_IC_TX :
    iflag_on[`CTX_I_RX] ? `CTX_IC_RX :
    iflag_on[`CTX_I_WAKE] ? `CTX_IC_WAKE : `CTX_IC_NONE; // [R20]

  // ************************************************
  // Submodules
  // ************************************************
  ctx_tx_pick u_pick (
    .ready(ready),
    .prio(prio_reg),
    .valid(pick_valid),
    .idx(pick_idx)
  );

  ctx_err_state u_err (
    .pclk(pclk),
    .presetn(presetn),
    .tec(tec),
    .rec(rec),
    .recessive_11(recessive_11),
    .err_mode(err_mode),
    .status(est),
    .recovered(recovered)
  );

  // ************************************************
  // Buffer control
  // ************************************************
  always_comb begin
    treq_next = treq_reg;
    abtd_next = abtd_reg;
    arbl_next = arbl_reg;
    terr_next = terr_reg;
    abtp_next = abtp_reg;
    remote_reply_enable_next = remote_reply_enable_reg;
    prio_next = prio_reg;
    bdone_next = bdone_reg & ~bdone_clr;
    ctl_wr = 1'b0;
    rtr_i = 1'b0;
    cur_i = 1'b0;
    set_req = 1'b0;
    abort_any = 1'b0;
    for (int i = 0; i < NB; i++) begin
      ctl_wr = wr & bctl_hit & (bidx == 3'(i));
      rtr_i = rtr_hit & mode_on & dirsel_reg[i] & remote_reply_enable_reg[i] &
        (rtr_buf == 3'(i)); // [R1]
      cur_i = busy & (cur_reg == 3'(i));
      abort_any = abtp_reg[i] | abort_all_request_reg;
      set_req = ~treq_reg[i] &
        ((ctl_wr & pwdata[`CTX_B_TREQ]) | rtr_i); // [R1]
      if (ctl_wr & ~treq_reg[i]) begin
        remote_reply_enable_next[i] = pwdata[`CTX_B_REMOTE_REPLY_ENABLE]; // [R4]
        prio_next[2*i +: 2] = pwdata[`CTX_B_PRIO_HI:`CTX_B_PRIO_LO];
      end
      // Clearing the request while pending is an abort, not a write
      if (ctl_wr & treq_reg[i] &
          (~pwdata[`CTX_B_TREQ] | pwdata[`CTX_B_ABTD])) begin
        abtp_next[i] = 1'b1; // [R11] [R14]
      end
      if (set_req) begin
        treq_next[i] = 1'b1;
        abtd_next[i] = 1'b0; // [R6]
        arbl_next[i] = 1'b0; // [R6]
        terr_next[i] = 1'b0; // [R6]
      end
      if (cur_i & tx_evt.done) begin
        treq_next[i] = 1'b0; // [R8] [R13]
        bdone_next[i] = 1'b1; // [R8]
      end
      if (cur_i & tx_evt.arb_lost) begin
        arbl_next[i] = 1'b1; // [R10]
      end
      if (cur_i & tx_evt.error) begin
        terr_next[i] = 1'b1; // [R9]
      end
      if (abort_any & treq_reg[i] &
          ((~cur_i) | (tx_evt.arb_lost | tx_evt.error))) begin
        treq_next[i] = 1'b0; // [R12]
        abtd_next[i] = 1'b1; // [R12]
      end
      if (!treq_next[i]) begin
        abtp_next[i] = 1'b0; // [R14]
      end
    end
  end

  // Abort-all drops itself once nothing is pending
  always_comb begin
    abort_all_request_next = abort_all_request_reg;
    if (abort_all_request_reg && treq_next == '0) begin
      abort_all_request_next = 1'b0; // [R14]
    end
    if (wr && paddr == `CTX_A_MODCTL && pwdata[`CTX_B_ABORT_ALL_REQUEST]) begin
      abort_all_request_next = 1'b1; // [R11]
    end
  end

  // ************************************************
  // Interrupt flags
  // ************************************************
  always_comb begin
    iflag_set = '0;
    iflag_set[`CTX_I_RX] = rx_done; // [R22]
    iflag_set[`CTX_I_TX] = busy & tx_evt.done; // [R21]
    iflag_set[`CTX_I_ERR] = err_evt; // [R21] [R22]
    iflag_set[`CTX_I_WAKE] = wake; // [R22]
    iflag_set[`CTX_I_BERR] = busy & tx_evt.error; // [R9]
  end

  // ************************************************
  // Transmit sequencing
  // ************************************************
  always_comb begin
    case (st_reg)
      CTX_TX_IDLE: st_next = start ? CTX_TX_BUSY : CTX_TX_IDLE;
      CTX_TX_BUSY: st_next = tx_end ? CTX_TX_IDLE : CTX_TX_BUSY;
      default: st_next = CTX_TX_IDLE;
    endcase
  end

  // ************************************************
  // Read data
  // ************************************************
  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr == `CTX_A_MODCTL) begin
      rdata[`CTX_B_MODE_HI:`CTX_B_MODE_LO] = mode_reg;
      rdata[`CTX_B_ABORT_ALL_REQUEST] = abort_all_request_reg;
    end else if (paddr == `CTX_A_MODST) begin
      rdata[`CTX_B_IRQ_CODE_HI:`CTX_B_IRQ_CODE_LO] = irq_code; // [R20]
    end else if (paddr == `CTX_A_COMST) begin
      rdata = {err_mode, 4'h0, tec, rec, 2'h0, est}; // [R15]
    end else if (paddr == `CTX_A_IFLAG) begin
      rdata[`CTX_NIRQ-1:0] = iflag_reg; // [R19]
    end else if (paddr == `CTX_A_IEN) begin
      rdata[7:0] = ien_reg; // [R19]
    end else if (paddr == `CTX_A_DIRSEL) begin
      rdata[NB-1:0] = dirsel_reg;
    end else if (paddr == `CTX_A_BIEN) begin
      rdata[NB-1:0] = bien_reg;
    end else if (paddr == `CTX_A_BDONE) begin
      rdata[NB-1:0] = bdone_reg;
    end else if (bctl_hit) begin
      rdata[`CTX_B_TREQ] = treq_reg[bidx];
      rdata[`CTX_B_ABTD] = abtd_reg[bidx];
      rdata[`CTX_B_ARBL] = arbl_reg[bidx];
      rdata[`CTX_B_TERR] = terr_reg[bidx];
      rdata[`CTX_B_REMOTE_REPLY_ENABLE] = remote_reply_enable_reg[bidx];
      rdata[`CTX_B_PRIO_HI:`CTX_B_PRIO_LO] = prio_reg[2*bidx +: 2];
    end else if (bmem_hit) begin
      rdata = mem[midx];
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      treq_reg <= '0;
      abtd_reg <= '0;
      arbl_reg <= '0;
      terr_reg <= '0;
      abtp_reg <= '0;
      remote_reply_enable_reg <= '0;
      prio_reg <= '0;
      bdone_reg <= '0;
      abort_all_request_reg <= 1'b0;
      iflag_reg <= '0;
      est_prev_reg <= 6'h00;
      treq_prev_reg <= '0;
    end else begin
      treq_reg <= treq_next;
      abtd_reg <= abtd_next;
      arbl_reg <= arbl_next;
      terr_reg <= terr_next;
      abtp_reg <= abtp_next;
      remote_reply_enable_reg <= remote_reply_enable_next;
      prio_reg <= prio_next;
      bdone_reg <= bdone_next;
      abort_all_request_reg <= abort_all_request_next;
      // A new event wins over a clear in the same cycle
      iflag_reg <= (iflag_reg & ~iflag_clr) | iflag_set; // [R19]
      est_prev_reg <= est;
      treq_prev_reg <= treq_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 2'h0;
      ien_reg <= 8'h00;
      dirsel_reg <= '0;
      bien_reg <= '0;
    end else if (wr) begin
      if (paddr == `CTX_A_MODCTL) begin
        mode_reg <= pwdata[`CTX_B_MODE_HI:`CTX_B_MODE_LO];
      end
      if (paddr == `CTX_A_IEN) begin
        ien_reg <= pwdata[7:0]; // [R19]
      end
      if (paddr == `CTX_A_BIEN) begin
        bien_reg <= pwdata[NB-1:0];
      end
      if (dir_wr) begin
        dirsel_reg <= (dirsel_reg & treq_reg) |
          (pwdata[NB-1:0] & ~treq_reg); // [R2]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < 4 * NB; j++) begin
        mem[j] <= 32'h0000_0000;
      end
    end else if (mem_wr) begin
      mem[midx] <= pwdata; // [R2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= CTX_TX_IDLE;
      cur_reg <= 3'h0;
      frame_reg <= '0;
      tx_start_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tx_start_reg <= start;
      if (start) begin
        cur_reg <= pick_idx; // [R7]
        frame_reg.id <= mem[ctx_mem_at(pick_idx, 2'h0)];
        frame_reg.dlc <= mem[ctx_mem_at(pick_idx, 2'h1)][3:0];
        frame_reg.data <= {mem[ctx_mem_at(pick_idx, 2'h3)],
          mem[ctx_mem_at(pick_idx, 2'h2)]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      pready_reg <= rd_load;
      pslverr_reg <= rd_load & ~mapped;
      if (rd_load) begin
        prdata_reg <= rdata;
      end
      irq_reg <= (|iflag_on) | (|(bdone_reg & bien_reg)); // [R8]
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_start = tx_start_reg;
  assign tx_frame = frame_reg;
  assign tx_buf = cur_reg;
  assign busoff_recovered = recovered;
  assign irq = irq_reg;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pending_ctl_locked: assert property ( // [R2]
    wr && bctl_hit && treq_reg[bidx] |=> $stable(remote_reply_enable_reg))
    else $error("pending control written");
  a_req_clears_flags: assert property ( // [R6]
    set_req_any |-> (new_req & (abtd_reg | arbl_reg | terr_reg)) == '0)
    else $error("flags kept on new request");
  a_start_on_idle: assert property ( // [R7]
    tx_start |-> $past(bus_idle) && busy)
    else $error("start without idle bus");
  a_done_clears_req: assert property ( // [R8]
    busy && tx_evt.done |=> !treq_reg[$past(cur_reg)] &&
      bdone_reg[$past(cur_reg)] && !abtd_reg[$past(cur_reg)])
    else $error("success not recorded");
  a_err_keeps_req: assert property ( // [R9]
    busy && tx_evt.error && !cur_abort |=> treq_reg[$past(cur_reg)] &&
      terr_reg[$past(cur_reg)] ##1 iflag_reg[`CTX_I_BERR])
    else $error("error not recorded");
  a_arb_keeps_req: assert property ( // [R10]
    busy && tx_evt.arb_lost && !cur_abort |=> treq_reg[$past(cur_reg)]
      && arbl_reg[$past(cur_reg)])
    else $error("arbitration loss not recorded");
  a_abort_all_held: assert property ( // [R14]
    $fell(abort_all_request_reg) |-> treq_reg == '0)
    else $error("abort-all dropped early");
  a_auto_reply: assert property ( // [R1]
    rtr_hit && mode_on && dirsel_reg[rtr_buf] && remote_reply_enable_reg[rtr_buf] |=>
      treq_reg[$past(rtr_buf)])
    else $error("remote reply not queued");
  a_irq_enabled: assert property ( // [R19]
    iflag_reg[`CTX_I_ERR] && ien_reg[`CTX_I_ERR] |=> irq)
    else $error("interrupt not raised");
endmodule

/* File: verif/ctx_engine_model.sv */
`timescale 1ns/1ps
module ctx_engine_model
  import ctx_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic hold,
  input wire logic [1:0] outcome,
  // Controller link
  input wire logic tx_start,
  output logic bus_idle,
  output ctx_tx_evt_t tx_evt
);
  logic run_reg;
  logic [4:0] cnt_reg;
  // Free only between frames, not in the start cycle
  assign bus_idle = !hold && !run_reg && !tx_start;
  // Long frame leaves room for a mid-frame abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      cnt_reg <= 5'h00;
      tx_evt <= '0;
    end else begin
      tx_evt <= '0;
      if (tx_start) begin
        run_reg <= 1'b1;
        cnt_reg <= 5'h14;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg == 5'h00) begin
          run_reg <= 1'b0;
          tx_evt <= {outcome == 2'h0, outcome == 2'h1, outcome == 2'h2};
        end
      end
    end
  end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "ctx_map.svh"
module tb;
  import ctx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic bus_idle, rtr_hit, rec11, tx_start, recov, irq, hold;
  logic [2:0] rtr_buf, tx_buf;
  logic [8:0] tec;
  logic [1:0] outcome;
  ctx_tx_evt_t tx_evt;
  ctx_frame_t tx_frame;
  int n_fail, comparisons, nrec;
  // ********
  // Design and far side
  // ********
  ctx_top i_ctx_top(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_idle(bus_idle), .tx_evt(tx_evt), .rtr_hit(rtr_hit),
    .rtr_buf(rtr_buf), .rx_done(1'b0), .rx_overrun(1'b0), .wake(1'b0),
    .recessive_11(rec11), .tec(tec), .rec(8'h00), .tx_start(tx_start),
    .tx_frame(tx_frame), .tx_buf(tx_buf), .busoff_recovered(recov),
    .irq(irq));
  ctx_engine_model i_ctx_engine_model(.pclk(pclk), .presetn(presetn),
    .hold(hold), .outcome(outcome), .tx_start(tx_start),
    .bus_idle(bus_idle), .tx_evt(tx_evt));
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (recov === 1'b1) nrec++;
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // Wait for a start (0) or any frame event (1)
  task automatic wt(input logic ev);
    int n;
    n = 0;
    while ((ev ? |tx_evt : tx_start) !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) n_fail++;
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  // ********
  // Sequence
  // ********
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; rtr_hit = 0; rtr_buf = 0; rec11 = 0;
    tec = 0; hold = 1; outcome = 0; n_fail = 0; comparisons = 0;
    nrec = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(`CTX_A_MODCTL, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1, `CTX_A_MODCTL, 32'h1);
    apb(1, `CTX_A_DIRSEL, 32'h3F);
    apb(1, `CTX_A_BIEN, 32'h1);
    apb(1, `CTX_A_IEN, 32'h6);
    apb(1, 8'h40, 32'h12345678);
    apb(1, 8'h44, 32'h8);
    apb(1, 8'h20, 32'h9);
    apb(1, 8'h40, 32'hFFFFFFFF);
    rc(8'h40, 32'hFFFFFFFF, 32'h12345678);
    hold <= 1'b0;
    wt(0);
    chk(tx_frame.id, 32'h12345678);
    hold <= 1'b1;
    wt(1);
    rc(8'h20, 32'h7F, 32'h01);
    rc(`CTX_A_BDONE, 32'h1, 32'h1);
    rc(`CTX_A_MODST, 32'hE, 32'h6);
    chk(irq, 32'h1);
    apb(1, `CTX_A_IFLAG, 32'h2);
    apb(1, `CTX_A_BDONE, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    apb(1, 8'h20, 32'h9);
    apb(1, 8'h20, 32'h1);
    rc(8'h20, 32'h7F, 32'h41);
    apb(1, 8'h20, 32'h1);
    rc(8'h20, 32'h7F, 32'h41);
    apb(1, 8'h20, 32'h9);
    rc(8'h20, 32'h7F, 32'h09);
    outcome <= 2'h1;
    hold <= 1'b0;
    wt(0);
    hold <= 1'b1;
    wt(1);
    rc(8'h20, 32'h28, 32'h28);
    outcome <= 2'h2;
    hold <= 1'b0;
    wt(0);
    hold <= 1'b1;
    wt(1);
    rc(8'h20, 32'h18, 32'h18);
    rc(`CTX_A_IFLAG, 32'h10, 32'h10);
    apb(1, `CTX_A_MODCTL, 32'h11);
    repeat (4) @(posedge pclk);
    rc(8'h20, 32'h48, 32'h40);
    outcome <= 2'h0;
    apb(1, 8'h20, 32'h9);
    hold <= 1'b0;
    wt(0);
    hold <= 1'b1;
    apb(1, 8'h20, 32'h1);
    wt(1);
    rc(8'h20, 32'h48, 32'h00);
    apb(1, 8'h24, 32'hB);
    apb(1, 8'h20, 32'h9);
    hold <= 1'b0;
    wt(0);
    chk(tx_buf, 32'h1);
    wt(1);
    wt(0);
    chk(tx_buf, 32'h0);
    hold <= 1'b1;
    wt(1);
    apb(1, 8'h60, 32'h0000ABCD);
    apb(1, 8'h28, 32'h4);
    rtr_buf <= 3'h2;
    rtr_hit <= 1'b1;
    @(posedge pclk);
    rtr_hit <= 1'b0;
    rc(8'h28, 32'hC, 32'hC);
    tec <= 9'h060;
    rc(`CTX_A_COMST, 32'h1, 32'h1);
    rc(`CTX_A_MODST, 32'hE, 32'h2);
    tec <= 9'h080;
    rc(`CTX_A_COMST, 32'hE0000010, 32'h40000010);
    tec <= 9'h100;
    rc(`CTX_A_COMST, 32'hE0000020, 32'h80000020);
    repeat (127) begin
      @(posedge pclk);
      rec11 <= 1'b1;
      @(posedge pclk);
      rec11 <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    chk(nrec, 32'h0);
    // Engine clears its counters as recovery ends
    rec11 <= 1'b1;
    tec <= 9'h000;
    @(posedge pclk);
    rec11 <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(nrec, 32'h1);
    tec <= 9'h000;
    rc(`CTX_A_COMST, 32'hE0000000, 32'h20000000);
    summarize();
  end
endmodule
